// ---- logic/rtc_regs.svh ----
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_STATUS_CONTROL 4'h0
`define OFS_COUNT_VALUE    4'h4
`define OFS_MATCH_LIMIT    4'h8

// ****************************************
// Reset values
// ****************************************
`define RST_STATUS_CONTROL 8'h00
`define RST_COUNT_VALUE    8'h00
`define RST_MATCH_LIMIT    8'h00
`define RST_PRESC          18'h00000

// ****************************************
// Field codes
// ****************************************
`define DIV_OFF            4'h0
`define READ_ZERO          32'h0000_0000
`define UPPER_ZERO         24'h00_0000
`define BE_LOW_LANE        0

`endif

// ---- logic/rtc_pkg.sv ----
`default_nettype none

package rtc_pkg;

    // ****************************************
    // Status and control layout
    // ****************************************
    typedef struct packed {
        logic       match_flag;
        logic [1:0] source_select;
        logic       match_irq_enable;
        logic [3:0] divider_select;
    } status_control_t;

    typedef logic [17:0] presc_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage : rtc_pkg

`default_nettype wire

// ---- logic/periodic_wakeup_counter.sv ----
`include "rtc_regs.svh"
`default_nettype none

module periodic_wakeup_counter
    import rtc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    // Count sources
    input  wire logic        low_power_osc_1khz,
    input  wire logic        external_ref_clock,
    input  wire logic        internal_ref_clock,
    // Processor debug state
    input  wire logic        debug_active,
    // Events
    output var  logic        irq,
    output var  logic        conv_trigger
);

    // ****************************************
    // Divide-by table
    // ****************************************
    function automatic presc_t div_value(
        input logic       dec_hi,
        input logic [3:0] code
    );
        presc_t v;
        v = 18'h00000;
        unique case ({dec_hi, code})
            5'h00: v = 18'h00000;
            5'h01: v = 18'h00008;
            5'h02: v = 18'h00020;
            5'h03: v = 18'h00040;
            5'h04: v = 18'h00080;
            5'h05: v = 18'h00100;
            5'h06: v = 18'h00200;
            5'h07: v = 18'h00400;
            5'h08: v = 18'h00001;
            5'h09: v = 18'h00002;
            5'h0A: v = 18'h00004;
            5'h0B: v = 18'h0000A;
            5'h0C: v = 18'h00010;
            5'h0D: v = 18'h00064;
            5'h0E: v = 18'h001F4;
            5'h0F: v = 18'h003E8;
            5'h10: v = 18'h00000;
            5'h11: v = 18'h00400;
            5'h12: v = 18'h00800;
            5'h13: v = 18'h01000;
            5'h14: v = 18'h02000;
            5'h15: v = 18'h04000;
            5'h16: v = 18'h08000;
            5'h17: v = 18'h10000;
            5'h18: v = 18'h003E8;
            5'h19: v = 18'h007D0;
            5'h1A: v = 18'h01388;
            5'h1B: v = 18'h02710;
            5'h1C: v = 18'h04E20;
            5'h1D: v = 18'h0C350;
            5'h1E: v = 18'h186A0;
            5'h1F: v = 18'h30D40;
        endcase
        return v;
    endfunction : div_value

    // ****************************************
    // Source synchronisers
    // ****************************************
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] level_r;
    wire  [2:0] src_raw;
    wire  [2:0] src_agree;
    wire  [2:0] level_nxt;
    wire  [2:0] src_rise;

    assign src_raw = {internal_ref_clock, external_ref_clock, low_power_osc_1khz};

    // Second and third stage must agree before a level counts
    assign src_agree = ~(sync2_r ^ sync3_r);
    assign level_nxt = (src_agree & sync3_r) | (~src_agree & level_r);
    assign src_rise  = src_agree & sync3_r & ~level_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
            level_r <= 3'h0;
        end
        else if (clk_en)
        begin
            sync1_r <= src_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            level_r <= level_nxt;
        end
    end

    // ****************************************
    // Register state
    // ****************************************
    status_control_t sc_r;
    logic [7:0]      count_r;
    logic [7:0]      limit_r;
    presc_t          presc_r;
    bus_state_t      bus_r;
    logic [31:0]     rdata_r;
    logic            waitreq_r;
    logic            irq_r;
    logic            trig_r;

    // ****************************************
    // Bus decode
    // ****************************************
    wire             bus_req;
    wire             bus_take;
    wire             lane0;
    wire             hit_sc;
    wire             hit_cnt;
    wire             hit_lim;
    wire             wr_sc;
    wire             wr_lim;
    wire             wr_cnt;
    wire [31:0]      rd_word;
    status_control_t wd;

    assign bus_req  = avs_read | avs_write;
    // Write lands only at the edge where waitrequest is seen low
    assign bus_take = (bus_r == BUS_ACK);
    assign lane0    = avs_byteenable[`BE_LOW_LANE];
    assign hit_sc   = (avs_address == `OFS_STATUS_CONTROL);
    assign hit_cnt  = (avs_address == `OFS_COUNT_VALUE);
    assign hit_lim  = (avs_address == `OFS_MATCH_LIMIT);
    assign wr_sc    = bus_take & avs_write & lane0 & hit_sc;
    assign wr_lim   = bus_take & avs_write & lane0 & hit_lim;
    assign wr_cnt   = bus_take & avs_write & hit_cnt;
    assign wd       = status_control_t'(avs_writedata[7:0]);

    // Count register has no write path at all
    assign rd_word = hit_sc  ? {`UPPER_ZERO, sc_r} :
                     hit_cnt ? {`UPPER_ZERO, count_r} :
                     hit_lim ? {`UPPER_ZERO, limit_r} :
                     `READ_ZERO;

    // ****************************************
    // Counting decode
    // ****************************************
    wire         sel_change;
    wire         restart;
    wire         flag_clr;
    wire         src_edge;
    wire         running;
    wire         presc_wrap;
    wire         tick;
    wire         hit;
    wire         flag_nxt;
    wire presc_t div_last;
    wire presc_t presc_nxt;
    wire [7:0]   count_nxt;

    // Only a differing source or divider restarts; any limit write with byte lane 0 enabled restarts, even with the same value
    assign sel_change = wr_sc & ((wd.source_select != sc_r.source_select)
                        | (wd.divider_select != sc_r.divider_select));
    assign restart    = sel_change | wr_lim;
    assign flag_clr   = wr_sc & wd.match_flag;

    assign src_edge = sc_r.source_select[1] ? src_rise[2] :
                      sc_r.source_select[0] ? src_rise[1] : src_rise[0];

    // Off code stops the prescaler; debug freezes prescaler and counter
    assign running    = (sc_r.divider_select != `DIV_OFF) & ~debug_active;
    assign div_last   = div_value(sc_r.source_select[0], sc_r.divider_select)
                        - 18'h00001;
    assign presc_wrap = (presc_r == div_last);
    assign tick       = running & src_edge & presc_wrap;

    // Flag rises on the step from the limit back to zero
    assign hit = tick & (count_r == limit_r);

    assign presc_nxt = restart ? `RST_PRESC :
                       !(running & src_edge) ? presc_r :
                       presc_wrap ? `RST_PRESC :
                       presc_r + 18'h00001;

    assign count_nxt = restart ? `RST_COUNT_VALUE :
                       !tick ? count_r :
                       hit ? `RST_COUNT_VALUE :
                       count_r + 8'h01;

    // A hit in the clearing cycle is kept: set beats clear
    assign flag_nxt = hit | (sc_r.match_flag & ~flag_clr);

    // ****************************************
    // Bus slave
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            bus_r     <= BUS_IDLE;
            waitreq_r <= 1'b1;
            rdata_r   <= `READ_ZERO;
        end
        else if (clk_en)
        begin
            unique case (bus_r)
                BUS_IDLE:
                begin
                    if (bus_req)
                    begin
                        bus_r     <= BUS_ACK;
                        waitreq_r <= 1'b0;
                        rdata_r   <= rd_word;
                    end
                end
                BUS_ACK:
                begin
                    bus_r     <= BUS_IDLE;
                    waitreq_r <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Control and counter
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sc_r    <= status_control_t'(`RST_STATUS_CONTROL);
            count_r <= `RST_COUNT_VALUE;
            limit_r <= `RST_MATCH_LIMIT;
            presc_r <= `RST_PRESC;
        end
        else if (clk_en)
        begin
            if (wr_sc)
            begin
                sc_r.source_select    <= wd.source_select;
                sc_r.match_irq_enable <= wd.match_irq_enable;
                sc_r.divider_select   <= wd.divider_select;
            end
            sc_r.match_flag <= flag_nxt;
            if (wr_lim)
            begin
                limit_r <= avs_writedata[7:0];
            end
            count_r <= count_nxt;
            presc_r <= presc_nxt;
        end
    end

    // ****************************************
    // Event outputs
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            irq_r  <= 1'b0;
            trig_r <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_r  <= sc_r.match_flag & sc_r.match_irq_enable;
            trig_r <= hit;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = waitreq_r;
    assign irq             = irq_r;
    assign conv_trigger    = trig_r;

    // ****************************************
    // Checks
    // ****************************************
    property p_flag_set;
        @(posedge clock) disable iff (!rst_n)
        clk_en && hit |=> sc_r.match_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("match flag not set after a hit");

    property p_flag_clr;
        @(posedge clock) disable iff (!rst_n)
        clk_en && flag_clr && !hit |=> !sc_r.match_flag ##1 (!irq_r || !$past(clk_en));
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("match flag or request not cleared by write");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        clk_en && sc_r.match_flag && sc_r.match_irq_enable |=> irq_r;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing while flag and enable set");

    property p_no_irq;
        @(posedge clock) disable iff (!rst_n)
        clk_en && !sc_r.match_irq_enable |=> !irq_r;
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("interrupt raised while disabled");

    property p_restart;
        @(posedge clock) disable iff (!rst_n)
        clk_en && restart |=> count_r == 8'h00 && presc_r == 18'h00000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("counters not cleared by restart");

    property p_wrap;
        @(posedge clock) disable iff (!rst_n)
        clk_en && tick && !restart && count_r == limit_r
        |=> count_r == 8'h00 && sc_r.match_flag;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap at the limit");

    property p_step;
        @(posedge clock) disable iff (!rst_n)
        clk_en && tick && !restart && count_r != limit_r
        |=> count_r == $past(count_r) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("counter did not step by one");

    // Checks held state, not the tick term, so a broken gate shows up
    property p_off;
        @(posedge clock) disable iff (!rst_n)
        clk_en && !restart && (sc_r.divider_select == `DIV_OFF || debug_active)
        |=> $stable(count_r) && $stable(presc_r);
    endproperty
    a_off: assert property (p_off)
        else $error("count step while off or in debug");

    property p_ro;
        @(posedge clock) disable iff (!rst_n)
        clk_en && wr_cnt && !tick && !restart |=> $stable(count_r);
    endproperty
    a_ro: assert property (p_ro)
        else $error("count register changed by a write");

    property p_trig;
        @(posedge clock) disable iff (!rst_n)
        clk_en && hit |=> conv_trigger ##1 (conv_trigger == $past(hit) || !$past(clk_en));
    endproperty
    a_trig: assert property (p_trig)
        else $error("converter trigger missing after a hit");

endmodule : periodic_wakeup_counter

`default_nettype wire

// ---- test/test_periodic_wakeup_counter.sv ----
`include "rtc_regs.svh"
`default_nettype none

module test_periodic_wakeup_counter;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Design signals
    // ****************************************
    logic        clock;
    logic        rst_n;
    logic        clk_en;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  src_pins;
    logic        debug_active;
    logic        irq;
    logic        conv_trigger;

    // ****************************************
    // Model state
    // ****************************************
    int          mismatches;
    int          n_checks;
    int          cycles;
    int          n_trig;
    int          m_cnt;
    int          m_presc;
    int          m_hits;
    logic        m_flag;
    logic        m_ie;
    logic [1:0]  m_src;
    logic [3:0]  m_div;
    logic [7:0]  m_lim;
    logic [31:0] seed;
    int          d0[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
    int          d1[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536,
                            1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};

    periodic_wakeup_counter i_dut (
        .clock              (clock),
        .rst_n              (rst_n),
        .clk_en             (clk_en),
        .avs_address        (avs_address),
        .avs_read           (avs_read),
        .avs_write          (avs_write),
        .avs_writedata      (avs_writedata),
        .avs_byteenable     (avs_byteenable),
        .avs_readdata       (avs_readdata),
        .avs_waitrequest    (avs_waitrequest),
        .low_power_osc_1khz (src_pins[0]),
        .external_ref_clock (src_pins[1]),
        .internal_ref_clock (src_pins[2]),
        .debug_active       (debug_active),
        .irq                (irq),
        .conv_trigger       (conv_trigger)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ****************************************
    // Checks and closing
    // ****************************************
    task end_sim;
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t register got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t irq got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task chk_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp)
        begin
            mismatches++;
            $display("MISMATCH %0t trigger count got %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt

    // Hang guard, well above the longest expected run
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            mismatches++;
            end_sim();
        end
    end

    always @(posedge clock)
    begin
        if (conv_trigger === 1'b1)
            n_trig++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // ****************************************
    // Bus master and model
    // ****************************************
    task bus(input logic rw, input logic [3:0] a, input logic [7:0] d,
             input logic [3:0] be, output logic [31:0] q);
        @(posedge clock);
        avs_read       <= ~rw;
        avs_write      <= rw;
        avs_address    <= a;
        avs_writedata  <= {24'h00_0000, d};
        avs_byteenable <= be;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0)
            @(posedge clock);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 8'h00, 4'hF, q);
    endtask : rd

    task wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
        if (be[0] && a == `OFS_STATUS_CONTROL)
        begin
            if (d[6:5] != m_src || d[3:0] != m_div)
            begin
                m_cnt   = 0;
                m_presc = 0;
            end
            m_src = d[6:5];
            m_ie  = d[4];
            m_div = d[3:0];
            if (d[7])
                m_flag = 1'b0;
        end
        else if (be[0] && a == `OFS_MATCH_LIMIT)
        begin
            m_lim   = d;
            m_cnt   = 0;
            m_presc = 0;
        end
    endtask : wr

    // Source edges spaced six clocks, beyond the synchroniser limit
    task pulse(input int pin, input int n);
        int sel;
        int dv;
        sel = (m_src >= 2) ? 2 : m_src;
        dv  = m_src[0] ? d1[m_div] : d0[m_div];
        repeat (n)
        begin
            @(posedge clock);
            src_pins[pin] <= 1'b1;
            repeat (3) @(posedge clock);
            src_pins[pin] <= 1'b0;
            repeat (2) @(posedge clock);
            if (pin == sel && m_div != 0 && debug_active !== 1'b1 && clk_en === 1'b1)
            begin
                m_presc++;
                if (m_presc >= dv)
                begin
                    m_presc = 0;
                    if (m_cnt == m_lim)
                    begin
                        m_cnt  = 0;
                        m_flag = 1'b1;
                        m_hits++;
                    end
                    else
                        m_cnt++;
                end
            end
        end
        repeat (6) @(posedge clock);
    endtask : pulse

    task check_all;
        logic [31:0] q;
        repeat (3) @(posedge clock);
        chk_bit(irq, m_flag & m_ie);
        rd(`OFS_STATUS_CONTROL, q);
        chk_reg(q, {24'h00_0000, m_flag, m_src, m_ie, m_div});
        rd(`OFS_COUNT_VALUE, q);
        chk_reg(q, {24'h00_0000, m_cnt[7:0]});
        chk_cnt(n_trig, m_hits);
    endtask : check_all

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [31:0] q;
        int          s;
        int          c;
        int          pin;
        clk_en = 1'b1;
        rst_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        src_pins = 3'h0;
        debug_active = 1'b0;
        {m_cnt, m_presc, m_hits, n_trig, mismatches, n_checks, cycles} = '0;
        {m_flag, m_ie, m_src, m_div, m_lim} = '0;
        seed = 32'hF68C;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rd(`OFS_MATCH_LIMIT, q);
        chk_reg(q, 32'h0000_0000);
        rd(4'hC, q);
        chk_reg(q, 32'h0000_0000);
        check_all();
        pulse(0, 4);
        check_all();
        wr(`OFS_MATCH_LIMIT, 8'hFF, 4'hF);
        rd(`OFS_MATCH_LIMIT, q);
        chk_reg(q, 32'h0000_00FF);
        seed = lfsr(seed);
        wr(`OFS_MATCH_LIMIT, 8'h02 + {5'h00, seed[2:0]}, 4'hF);
        wr(`OFS_STATUS_CONTROL, 8'h08, 4'hF);
        pulse(0, m_lim);
        check_all();
        pulse(1, 2);
        check_all();
        pulse(0, 1);
        check_all();
        seed = lfsr(seed);
        wr(`OFS_COUNT_VALUE, seed[7:0], 4'hF);
        pulse(0, 1);
        check_all();
        wr(`OFS_STATUS_CONTROL, 8'h80, 4'h0);
        wr(`OFS_STATUS_CONTROL, 8'h18, 4'hF);
        check_all();
        wr(`OFS_STATUS_CONTROL, 8'h98, 4'hF);
        check_all();
        pulse(0, 2);
        wr(`OFS_STATUS_CONTROL, 8'h18, 4'hF);
        check_all();
        seed = lfsr(seed);
        wr(`OFS_MATCH_LIMIT, seed[7:0] | 8'h10, 4'hF);
        check_all();
        pulse(0, 2);
        debug_active <= 1'b1;
        pulse(0, 3);
        debug_active <= 1'b0;
        // Frozen clock enable must swallow whole source pulses
        clk_en <= 1'b0;
        pulse(0, 2);
        clk_en <= 1'b1;
        pulse(0, 1);
        check_all();
        wr(`OFS_MATCH_LIMIT, 8'h00, 4'hF);
        pulse(0, 3);
        check_all();
        wr(`OFS_MATCH_LIMIT, 8'h10, 4'hF);
        // Codes 1 to 15 on source 0; other sources only code 8, plus code 1 on source 1, to bound run time
        for (s = 0; s < 4; s++)
        begin
            pin = (s >= 2) ? 2 : s;
            for (c = 1; c < 16; c++)
            begin
                if (s == 0 || c == 8 || (s == 1 && c == 1))
                begin
                    wr(`OFS_STATUS_CONTROL, {1'b1, s[1:0], 1'b0, c[3:0]}, 4'hF);
                    pulse(pin, (s[0] ? d1[c] : d0[c]) - 1);
                    check_all();
                    pulse(pin, 1);
                    check_all();
                end
            end
        end
        // Mid-run reset must bring everything back to defaults
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        {m_cnt, m_presc} = '0;
        {m_flag, m_ie, m_src, m_div, m_lim} = '0;
        rd(`OFS_MATCH_LIMIT, q);
        chk_reg(q, 32'h0000_0000);
        check_all();
        end_sim();
    end

endmodule : test_periodic_wakeup_counter

`default_nettype wire
